// >>> rtl/tnc_core_regs.v
// Token net node core: APB register bank, microsequencer, reconfiguration timer, buffer window.
// Assumes an APB master on pclk; sequencer rates are strobes derived from pclk.
//
// Function
// - 544 by 8 microprogram store, PC fetched
// - Derive 10 MHz and 5 MHz timing
// - PC steps at 10 MHz, executes 5 MHz
// - Opcode and immediate in separate registers
// - Decode before executing each instruction
// - No-op waits timed, PC frozen
// - Jump loads PC from store target
// - Reconfiguration_flag timeout clears PC, sets flag
// - Status register layout at address 00
// - Diagnostic register layout at address 01
// - Sub-address bits 7,3 kept, 6:4 zero
// - Configuration register layout at address 06
// - First setup register layout, index 2
// - Second setup register layout, index 4
// - Write 00 sets interrupt mask
// - Address 07 reads selected indirect register
// - Write 01 commands; index 3 test zeros
// - High pointer first; low write loads
// - Interrupt is OR of masked status and diagnostic bits
// - Diagnostic read clears all but two
// - Sequencer idle until own_node_identifier nonzero
`timescale 1ns/10ps
`include "tnc_core_map.vh"

module tnc_core_regs #(
  parameter [15:0] RECONFIGURATION_FLAG_BASE_TICKS = 16'h0FFF,
  parameter        BUF_AW           = 11
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq
);

  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_OP   = 6'b000010;
  localparam [5:0] S_IMM  = 6'b000100;
  localparam [5:0] S_DEC  = 6'b001000;
  localparam [5:0] S_EXE  = 6'b010000;
  localparam [5:0] S_WAIT = 6'b100000;
  localparam integer ROM_WORDS = `TNC_ROM_WORDS;
  localparam integer FAST_HZ   = `TNC_FAST_HZ;
  localparam integer PCLK_HZ   = `TNC_PCLK_HZ;
  // Sized on purpose; all three figures fit their fields
  localparam [9:0]  ROM_LAST = ROM_WORDS[9:0] - 10'd1;
  localparam [24:0] FAST_INC = FAST_HZ[24:0];
  localparam [24:0] PCLK_MOD = PCLK_HZ[24:0];

  reg  [7:0]        status;
  reg  [7:0]        diag;
  reg  [7:0]        int_mask;
  reg  [2:0]        ptr_hi;
  reg               read_prefetch;
  reg               pointer_increment;
  reg  [BUF_AW-1:0] buf_ptr;
  reg  [7:0]        data_reg;
  reg  [7:0]        buf_mem [0:(1<<BUF_AW)-1];
  reg  [2:0]        sel;
  reg               sa_bit7;
  reg               sa_bit3;
  reg  [7:0]        config_reg;
  reg  [7:0]        probe_id;
  reg  [7:0]        own_own_node_identifier;
  reg  [7:0]        first_setup;
  reg  [7:0]        second_setup;
  reg  [7:0]        factory_test;
  reg  [7:0]        successor_id;
  reg  [24:0]       phase_acc;
  reg               tick_10;
  reg               half;
  reg  [5:0]        state;
  reg  [9:0]        pc;
  reg  [7:0]        op_reg;
  reg  [7:0]        imm_reg;
  reg  [3:0]        dec_op;
  reg  [7:0]        wait_cnt;
  reg  [15:0]       reconfiguration_flag_cnt;
  reg               ev_next;
  reg  [31:0]       next_prdata;

  wire        acc_done   = psel & penable & pready;
  wire        wr_done    = acc_done & pwrite & ~pslverr;
  wire        rd_done    = acc_done & ~pwrite & ~pslverr;
  wire [2:0]  idx        = paddr[4:2];
  wire [7:0]  wd         = pwdata[7:0];
  wire        soft_reset = config_reg[`TNC_CF_SWRESET];
  wire        tick_5     = tick_10 & half;
  wire [15:0] reconfiguration_flag_lim  = RECONFIGURATION_FLAG_BASE_TICKS >> second_setup[1:0];
  wire        reconfiguration_flag_exp  = (state != S_IDLE) && (reconfiguration_flag_cnt >= reconfiguration_flag_lim);
  wire        ev_token   = (state == S_EXE) && tick_5 && (op_reg[7:4] == `TNC_OP_FLAG);
  wire        ev_flag_tk = ev_token & imm_reg[`TNC_DG_TOKEN];
  wire [7:0]  rom_now    = rom_word(pc);

  function [7:0] rom_word;
    input [9:0] a;
    begin
      case (a)
        10'd0:   rom_word = {`TNC_OP_FLAG, 4'h0};
        10'd1:   rom_word = 8'h30;
        10'd2:   rom_word = {`TNC_OP_NOP, 4'h0};
        10'd3:   rom_word = 8'h20;
        10'd4:   rom_word = {`TNC_OP_LDNXT, 4'h0};
        10'd5:   rom_word = 8'h01;
        10'd6:   rom_word = {`TNC_OP_JMP, 4'h0};
        10'd7:   rom_word = 8'h00;
        default: rom_word = 8'h00;
      endcase
    end
  endfunction

  function is_reg;
    input [2:0] i;
    input [2:0] want;
    begin
      is_reg = (i == want);
    end
  endfunction

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_acc <= 25'h0000000;
      tick_10   <= 1'b0;
      half      <= 1'b0;
    end
    else
    begin
      if (phase_acc + FAST_INC >= PCLK_MOD)
      begin
        phase_acc <= phase_acc + FAST_INC - PCLK_MOD;
        tick_10   <= 1'b1;
      end
      else
      begin
        phase_acc <= phase_acc + FAST_INC;
        tick_10   <= 1'b0;
      end
      if (tick_10)
        half <= ~half;
    end
  end

  // Microsequencer; a software reset holds it idle like a missing own_node_identifier
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= S_IDLE;
      pc           <= 10'h000;
      op_reg       <= 8'h00;
      imm_reg      <= 8'h00;
      dec_op       <= 4'h0;
      wait_cnt     <= 8'h00;
      reconfiguration_flag_cnt    <= 16'h0000;
      successor_id <= `TNC_RST_ID;
      ev_next      <= 1'b0;
    end
    else
    begin
      ev_next <= 1'b0;
      if (soft_reset)
        successor_id <= `TNC_RST_ID;
      if (ev_flag_tk || state == S_IDLE)
        reconfiguration_flag_cnt <= 16'h0000;
      else if (tick_5 && !reconfiguration_flag_exp)
        reconfiguration_flag_cnt <= reconfiguration_flag_cnt + 16'h0001;
      if (own_own_node_identifier == 8'h00 || soft_reset)
      begin
        state <= S_IDLE;
        pc    <= 10'h000;
      end
      else if (reconfiguration_flag_exp)
      begin
        state     <= S_OP;
        pc        <= 10'h000;
        reconfiguration_flag_cnt <= 16'h0000;
      end
      else
      begin
        case (state)
          S_IDLE:
            state <= S_OP;
          S_OP:
            if (tick_10)
            begin
              op_reg <= rom_now;
              pc     <= (pc == ROM_LAST) ? 10'h000 : pc + 10'h001;
              state  <= S_IMM;
            end
          S_IMM:
            if (tick_10)
            begin
              imm_reg <= rom_now;
              pc      <= (pc == ROM_LAST) ? 10'h000 : pc + 10'h001;
              state   <= S_DEC;
            end
          S_DEC:
            if (tick_5)
            begin
              dec_op <= op_reg[7:4];
              state  <= S_EXE;
            end
          S_EXE:
            if (tick_5)
            begin
              case (dec_op)
                `TNC_OP_NOP:
                begin
                  wait_cnt <= imm_reg;
                  state    <= S_WAIT;
                end
                `TNC_OP_JMP:
                begin
                  pc    <= ({op_reg[1:0], imm_reg} > ROM_LAST) ? 10'h000 : {op_reg[1:0], imm_reg};
                  state <= S_OP;
                end
                `TNC_OP_LDNXT:
                begin
                  successor_id <= imm_reg;
                  ev_next      <= (imm_reg != successor_id);
                  state        <= S_OP;
                end
                default:
                  state <= S_OP;
              endcase
            end
          S_WAIT:
            if (tick_5)
            begin
              if (wait_cnt == 8'h00)
                state <= S_OP;
              else
                wait_cnt <= wait_cnt - 8'h01;
            end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end

  // APB: one wait state, answer registered with pready
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (paddr >= `TNC_ADDR_LIMIT || paddr[1:0] != 2'b00);
      if (psel & penable & ~pready)
        prdata <= next_prdata;
    end
  end

  // Read mux
  always @*
  begin
    next_prdata = 32'h00000000;
    if (!pwrite && paddr < `TNC_ADDR_LIMIT)
    begin
      case (idx)
        `TNC_IDX_STATUS:   next_prdata[7:0] = status;
        `TNC_IDX_DIAG:     next_prdata[7:0] = {diag[7:1], 1'b0};
        `TNC_IDX_PTR_HI:   next_prdata[7:0] = {read_prefetch, pointer_increment, 3'b000, ptr_hi};
        `TNC_IDX_PTR_LO:   next_prdata[7:0] = buf_ptr[7:0];
        `TNC_IDX_DATA:     next_prdata[7:0] = data_reg;
        `TNC_IDX_SUBADR:   next_prdata[7:0] = {sa_bit7, 3'b000, sa_bit3, sel};
        `TNC_IDX_CONFIG:   next_prdata[7:0] = {config_reg[7:2], sel[1:0]};
        default:
        begin
          if (is_reg(sel, `TNC_SEL_PROBE))
            next_prdata[7:0] = probe_id;
          else if (is_reg(sel, `TNC_SEL_NODE))
            next_prdata[7:0] = own_own_node_identifier;
          else if (is_reg(sel, `TNC_SEL_FIRST_SETUP))
            next_prdata[7:0] = first_setup;
          else if (is_reg(sel, `TNC_SEL_NEXT))
            next_prdata[7:0] = successor_id;
          else if (is_reg(sel, `TNC_SEL_SECOND_SETUP))
            next_prdata[7:0] = second_setup;
        end
      endcase
    end
  end

  // Host-visible register state and flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status            <= `TNC_RST_STATUS;
      diag              <= `TNC_RST_DIAG;
      int_mask          <= `TNC_RST_MASK;
      ptr_hi            <= 3'b000;
      read_prefetch     <= 1'b0;
      pointer_increment <= 1'b0;
      buf_ptr           <= {BUF_AW{1'b0}};
      data_reg          <= 8'h00;
      sel               <= 3'b000;
      sa_bit7           <= 1'b0;
      sa_bit3           <= 1'b0;
      config_reg        <= `TNC_RST_CONFIG;
      probe_id          <= `TNC_RST_ID;
      own_own_node_identifier       <= `TNC_RST_ID;
      first_setup       <= 8'h00;
      second_setup      <= 8'h00;
      factory_test      <= 8'h00;
      irq               <= 1'b0;
    end
    else
    begin
      irq <= |({status[`TNC_ST_RI], diag[`TNC_DG_EXCESS_NEGATIVE_ACK_FLAG], status[`TNC_ST_RECONFIGURATION_FLAG], diag[`TNC_DG_NEWNXT],
                status[`TNC_ST_TA]} & {int_mask[7], int_mask[3:0]});
      // read clears, events set afterwards so they win
      if (rd_done && idx == `TNC_IDX_DIAG)
        diag <= diag & ((8'h01 << `TNC_DG_EXCESS_NEGATIVE_ACK_FLAG) | (8'h01 << `TNC_DG_NEWNXT));
      if (rd_done && idx == `TNC_IDX_INDIRECT && sel == `TNC_SEL_NEXT)
        diag[`TNC_DG_NEWNXT] <= 1'b0;
      if (rd_done && idx == `TNC_IDX_DATA)
      begin
        data_reg <= buf_mem[buf_ptr + (pointer_increment ? 1'b1 : 1'b0)];
        if (pointer_increment)
          buf_ptr <= buf_ptr + 1'b1;
      end
      if (wr_done)
      begin
        case (idx)
          `TNC_IDX_STATUS: int_mask <= wd & `TNC_MASK_WMASK;
          `TNC_IDX_DIAG:
            if ({1'b0, wd[2:0]} == `TNC_CMD_CLRFLAGS && wd[7:5] == 3'b000)
            begin
              if (wd[`TNC_CMD_ARG_POR])
              begin
                status[`TNC_ST_POR]  <= 1'b0;
                diag[`TNC_DG_EXCESS_NEGATIVE_ACK_FLAG] <= 1'b0;
              end
              if (wd[`TNC_CMD_ARG_RCN])
                status[`TNC_ST_RECONFIGURATION_FLAG] <= 1'b0;
            end
          `TNC_IDX_PTR_HI:
          begin
            ptr_hi            <= wd[2:0];
            read_prefetch     <= wd[`TNC_PH_PREFETCH];
            pointer_increment <= wd[`TNC_PH_POINTER_INCREMENT];
          end
          `TNC_IDX_PTR_LO:
          begin
            buf_ptr <= {ptr_hi, wd};
            if (read_prefetch)
              data_reg <= buf_mem[{ptr_hi, wd}];
          end
          `TNC_IDX_DATA:
          begin
            data_reg <= wd;
            if (pointer_increment)
              buf_ptr <= buf_ptr + 1'b1;
          end
          `TNC_IDX_SUBADR:
          begin
            sa_bit7 <= wd[7];
            sa_bit3 <= wd[3];
            sel     <= wd[2:0];
          end
          `TNC_IDX_CONFIG:
          begin
            config_reg <= {wd[7:2], 2'b00};
            sel[1:0]   <= wd[1:0];
          end
          default:
          begin
            if (is_reg(sel, `TNC_SEL_PROBE))
              probe_id <= wd;
            else if (is_reg(sel, `TNC_SEL_NODE))
              own_own_node_identifier <= wd;
            else if (is_reg(sel, `TNC_SEL_FIRST_SETUP))
              first_setup <= wd & `TNC_FIRST_SETUP_WMASK;
            else if (is_reg(sel, `TNC_SEL_NEXT))
              factory_test <= wd;
            else if (is_reg(sel, `TNC_SEL_SECOND_SETUP))
              second_setup <= wd & `TNC_SECOND_SETUP_WMASK;
          end
        endcase
      end
      if (soft_reset)
      begin
        status <= `TNC_RST_STATUS;
        diag   <= `TNC_RST_DIAG;
      end
      else
      begin
        if (reconfiguration_flag_exp)
        begin
          diag[`TNC_DG_MYRC]    <= 1'b1;
          status[`TNC_ST_RECONFIGURATION_FLAG] <= 1'b1;
        end
        if (ev_token)
          diag[6:2] <= diag[6:2] | imm_reg[6:2];
        if (ev_next)
          diag[`TNC_DG_NEWNXT] <= 1'b1;
      end
    end
  end

  // Buffer RAM write port, no reset on the array
  always @(posedge pclk)
  begin
    if (wr_done && idx == `TNC_IDX_DATA)
      buf_mem[buf_ptr] <= wd;
  end

endmodule

// >>> rtl/tnc_core_map.vh
// Register offsets, field positions, reset values and timing figures for the token net core.
// Assumes plain Verilog-2005 includers; definitions only.
`ifndef TNC_CORE_MAP_VH
`define TNC_CORE_MAP_VH

// Register indices; byte address is four times the index
`define TNC_IDX_STATUS   3'h0
`define TNC_IDX_DIAG     3'h1
`define TNC_IDX_PTR_HI   3'h2
`define TNC_IDX_PTR_LO   3'h3
`define TNC_IDX_DATA     3'h4
`define TNC_IDX_SUBADR   3'h5
`define TNC_IDX_CONFIG   3'h6
`define TNC_IDX_INDIRECT 3'h7
`define TNC_ADDR_LIMIT   12'h020

// Indirect selector values at index 7
`define TNC_SEL_PROBE    3'h0
`define TNC_SEL_NODE     3'h1
`define TNC_SEL_FIRST_SETUP   3'h2
`define TNC_SEL_NEXT     3'h3
`define TNC_SEL_SECOND_SETUP   3'h4

// Status bit positions
`define TNC_ST_RI        7
`define TNC_ST_POR       4
`define TNC_ST_TEST      3
`define TNC_ST_RECONFIGURATION_FLAG     2
`define TNC_ST_TMA       1
`define TNC_ST_TA        0

// Diagnostic bit positions
`define TNC_DG_MYRC      7
`define TNC_DG_DUP       6
`define TNC_DG_RCV       5
`define TNC_DG_TOKEN     4
`define TNC_DG_EXCESS_NEGATIVE_ACK_FLAG    3
`define TNC_DG_PROBE     2
`define TNC_DG_NEWNXT    1

// Pointer high, configuration and sub-address fields
`define TNC_PH_PREFETCH  7
`define TNC_PH_POINTER_INCREMENT   6
`define TNC_CF_SWRESET   7
`define TNC_SA_KEEP_MASK 8'h88

// Reset values and write masks
`define TNC_RST_STATUS   8'h91
`define TNC_RST_DIAG     8'h00
`define TNC_RST_CONFIG   8'h18
`define TNC_RST_MASK     8'h00
`define TNC_RST_ID       8'h00
`define TNC_MASK_WMASK   8'h8F
`define TNC_FIRST_SETUP_WMASK 8'hDF
`define TNC_SECOND_SETUP_WMASK 8'hBF

// Command codes and argument bits
`define TNC_CMD_CLRFLAGS 4'h6
`define TNC_CMD_ARG_POR  3
`define TNC_CMD_ARG_RCN  4

// Microinstruction opcodes, upper nibble of the opcode byte
`define TNC_OP_NOP       4'h0
`define TNC_OP_JMP       4'h1
`define TNC_OP_LDNXT     4'h2
`define TNC_OP_FLAG      4'h3

// Sequencer timing and store size
`define TNC_PCLK_HZ      25000000
`define TNC_FAST_HZ      10000000
`define TNC_ROM_WORDS    544

`endif

// >>> sim/tnc_host_model.sv
// Host model: APB master in place of the node's microcontroller.
// Assumes one pclk domain; the slave ends each access with pready.
`timescale 1ns/10ps
module tnc_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hFFF;
    pwdata = 32'hFFFFFFFF;
  end

  // Request held until pready is seen or 64 cycles pass; an idle bus shows inverted address and data, while pwrite keeps its last value
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic err, output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    q = prdata[7:0];
    err = pslverr;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~{24'h000000, d};
  endtask
endmodule

// >>> sim/tnc_core_regs_assertions.sv
// Checker for the token net core APB slave and interrupt output.
// Assumes a bind to tnc_core_regs; one pclk domain, async low reset.
`timescale 1ns/10ps
module tnc_core_regs_chk #(
  parameter [15:0] RECONFIGURATION_FLAG_BASE_TICKS = 16'h0FFF,
  parameter        BUF_AW           = 11
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire take = psel && penable && pready;

  a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_only: assert property (pslverr |-> pready)
    else $error("pslverr outside completion");
  a_err_range: assert property (take && (paddr >= 12'h020 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("bad address not refused");
  a_err_legal: assert property (take && paddr < 12'h020 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("legal address refused");
  a_err_data: assert property (take && pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  a_rdata_upper: assert property (take |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_sub_zero: assert property (take && !pwrite && paddr == 12'h014 |-> prdata[6:4] == 3'b000)
    else $error("selector bits 6 to 4 not zero");
  a_mask_off: assert property (take && pwrite && paddr == 12'h000 && (pwdata[7:0] & 8'h8F) == 8'h00
    |-> ##2 !irq)
    else $error("irq high with empty mask");
  a_irq_quiet: assert property ($rose(presetn) |-> !irq [*3])
    else $error("irq after reset with mask clear");

  cover property (take && !pwrite && paddr == 12'h000);
  cover property ($rose(irq));
  cover property (take && pslverr);
endmodule

bind tnc_core_regs tnc_core_regs_chk #(.RECONFIGURATION_FLAG_BASE_TICKS(RECONFIGURATION_FLAG_BASE_TICKS), .BUF_AW(BUF_AW)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// >>> sim/tnc_core_regs_tb.sv
// Testbench for the token net core register bank.
// Assumes the host model as APB master and the default microprogram.
`timescale 1ns/10ps
`include "tnc_core_map.vh"
module tnc_core_regs_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  int          n_fail;
  int          compares;

  tnc_core_regs #(.RECONFIGURATION_FLAG_BASE_TICKS(16'h0FFF), .BUF_AW(11)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  tnc_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic report_and_stop;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A hung bus ends the run at once
  task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d, output logic [7:0] q);
    logic err;
    logic to;
    i_host.xfer(w, {7'h00, idx, 2'b00}, d, q, err, to);
    if (to)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [2:0] idx, output logic [7:0] q);
    bus(1'b0, idx, 8'h00, q);
  endtask

  task automatic rdc(input logic [2:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    rd(idx, q);
    chk(q, exp);
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 8)
    begin
      @(negedge pclk);
      n++;
    end
    chk({7'h00, irq}, {7'h00, exp});
  endtask

  task automatic test_reset;
    repeat (100) @(posedge pclk);
    rdc(`TNC_IDX_STATUS, 8'h91);
    rdc(`TNC_IDX_DIAG, 8'h00);
    rdc(`TNC_IDX_CONFIG, 8'h18);
    wr(`TNC_IDX_SUBADR, 8'h01);
    rdc(`TNC_IDX_INDIRECT, 8'h00);
    $display("reset test done");
  endtask

  task automatic test_irq;
    wr(`TNC_IDX_STATUS, 8'h01);
    wait_irq(1'b1);
    wr(`TNC_IDX_STATUS, 8'h70);
    wait_irq(1'b0);
    wr(`TNC_IDX_STATUS, 8'h80);
    wait_irq(1'b1);
    wr(`TNC_IDX_STATUS, 8'h0C);
    wait_irq(1'b0);
    $display("irq test done");
  endtask

  task automatic test_cmd;
    wr(`TNC_IDX_DIAG, 8'h1E);
    rdc(`TNC_IDX_STATUS, 8'h81);
    $display("command test done");
  endtask

  task automatic test_indirect;
    logic [2:0] sel [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
    logic [7:0] wv [4] = '{8'hA5, 8'hFF, 8'h00, 8'hFC};
    logic [7:0] ev [4] = '{8'hA5, 8'hDF, 8'h00, 8'hBC};
    wr(`TNC_IDX_SUBADR, 8'hFF);
    rdc(`TNC_IDX_SUBADR, 8'h8F);
    rdc(`TNC_IDX_CONFIG, 8'h1B);
    rdc(`TNC_IDX_INDIRECT, 8'h00);
    wr(`TNC_IDX_CONFIG, 8'h1A);
    rdc(`TNC_IDX_SUBADR, 8'h8E);
    for (int i = 0; i < 4; i++)
    begin
      wr(`TNC_IDX_SUBADR, {5'h00, sel[i]});
      wr(`TNC_IDX_INDIRECT, wv[i]);
      rdc(`TNC_IDX_INDIRECT, ev[i]);
    end
    $display("indirect test done");
  endtask

  task automatic test_buffer;
    wr(`TNC_IDX_PTR_HI, 8'h45);
    wr(`TNC_IDX_PTR_LO, 8'h10);
    wr(`TNC_IDX_DATA, 8'h11);
    wr(`TNC_IDX_DATA, 8'h22);
    wr(`TNC_IDX_PTR_HI, 8'hC5);
    wr(`TNC_IDX_PTR_LO, 8'h10);
    rdc(`TNC_IDX_DATA, 8'h11);
    rdc(`TNC_IDX_DATA, 8'h22);
    rdc(`TNC_IDX_PTR_HI, 8'hC5);
    $display("buffer test done");
  endtask

  task automatic test_errors;
    logic [7:0] q;
    logic err;
    logic to;
    i_host.xfer(1'b0, 12'h020, 8'h00, q, err, to);
    chk({err, to, q[5:0]}, 8'h80);
    i_host.xfer(1'b1, 12'h002, 8'h55, q, err, to);
    chk({err, to, 6'h00}, 8'h80);
    $display("error test done");
  endtask

  task automatic test_sequencer;
    logic [7:0] q;
    int n;
    wr(`TNC_IDX_SUBADR, 8'h01);
    wr(`TNC_IDX_INDIRECT, 8'h01);
    n = 0;
    q = 8'h00;
    while (q[`TNC_DG_NEWNXT] !== 1'b1 && n < 1000)
    begin
      rd(`TNC_IDX_DIAG, q);
      n++;
    end
    chk(q & 8'h02, 8'h02);
    rd(`TNC_IDX_DIAG, q);
    chk(q & 8'h0A, 8'h02);
    wr(`TNC_IDX_STATUS, 8'h02);
    wait_irq(1'b1);
    wr(`TNC_IDX_SUBADR, 8'h03);
    rdc(`TNC_IDX_INDIRECT, 8'h01);
    wait_irq(1'b0);
    $display("sequencer test done");
  endtask

  initial
  begin
    n_fail = 0;
    compares = 0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_irq();
    test_cmd();
    test_indirect();
    test_buffer();
    test_errors();
    test_sequencer();
    report_and_stop();
  end
endmodule
